/* hdl/rss_reset_seq.sv */
// Reset source sequencer top: combines power-on, pin, low-supply and watchdog resets,
// runs the start-up delay and holds the pin select and reset flag registers.
// Assumes an Avalon-MM master on sys_clk and asynchronous pin inputs.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`include "rss_defines.svh"
module rss_reset_seq
    import rss_pkg::*;
#(
    parameter int unsigned LONG_CYC = `RSS_LONG_CYC,
    parameter int unsigned SHORT_CYC = `RSS_SHORT_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic external_init_pin_n,
    input wire logic low_supply_det,
    input wire logic slow_internal_osc,
    input wire logic cpu_halted,
    input wire logic wdt_timeout,
    input wire logic wdt_ctl_fault,
    input wire logic halt_exec,
    input wire logic clr_wdt_exec,
    output logic core_reset,
    output logic port_preset,
    output logic pc_sp_clear,
    output logic pin_is_reset_fn,
    output logic idle_clock_keep
);
    // ==========================================
    // Reset release and pin synchroniser
    logic rst_s1, rst_n_i;
    logic pin_s1, pin_s2;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1 <= 1'b0;
            rst_n_i <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n_i <= rst_s1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else begin
            pin_s1 <= external_init_pin_n;
            pin_s2 <= pin_s1;
        end
    end

    // ==========================================
    // Bus decode
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
        return addr == ofs;
    endfunction

    logic ack;
    logic req, wr_ok;
    logic hit_pinsel, hit_mode1, hit_stat;
    logic wr_pinsel, wr_mode1;
    logic [31:0] rd_mux;

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign wr_ok = avs_write & ack;
    assign hit_pinsel = hit(avs_address, `RSS_OFS_PINSEL);
    assign hit_mode1 = hit(avs_address, `RSS_OFS_MODE1);
    assign hit_stat = hit(avs_address, `RSS_OFS_STAT);
    assign wr_pinsel = wr_ok & hit_pinsel;
    assign wr_mode1 = wr_ok & hit_mode1;

    // ==========================================
    // Register state
    logic [7:0] pinsel;
    logic keep, spare, low_supply_flag, watchdog_ctl_fault_flag, to_flag, powerdown_flag;

    assign rd_mux = hit_pinsel ? {24'h000000, pinsel}
                  : hit_mode1 ? {24'h000000, keep, 3'h0, spare, low_supply_flag, 1'b0, watchdog_ctl_fault_flag}
                  : hit_stat ? {30'h00000000, powerdown_flag, to_flag}
                  : 32'h00000000;

    always_ff @(posedge sys_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            ack <= req & ~ack;
            if (req && !ack) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ==========================================
    // Source combining
    logic lvr_req;
    logic src_pin, src_evt, any_src;
    logic wdt_run, wdt_halt;

    // Bits 3:2 are read-only, so only the writable bits carry the code
    assign pin_is_reset_fn = ((pinsel & `RSS_PINSEL_WMASK) == (`RSS_PINSEL_RESET & `RSS_PINSEL_WMASK));
    assign src_pin = pin_is_reset_fn & ~pin_s2;
    assign wdt_run = wdt_timeout & ~cpu_halted;
    assign wdt_halt = wdt_timeout & cpu_halted;
    assign src_evt = wdt_run | wdt_ctl_fault;
    assign any_src = src_pin | lvr_req | src_evt;

    rss_lvr_qual u_lvr (
        .sys_clk(sys_clk),
        .rst_n(rst_n_i),
        .low_supply_det(low_supply_det),
        .slow_internal_osc(slow_internal_osc),
        .monitor_on(~cpu_halted),
        .lvr_req(lvr_req)
    );

    // ==========================================
    // Sequencer
    rss_state_t state, next_state;
    logic long_sel, warm;
    logic next_long, next_warm;
    rss_tmr_if tif ();

    rss_start_timer #(
        .LONG_CYC(LONG_CYC),
        .SHORT_CYC(SHORT_CYC)
    ) u_tmr (
        .sys_clk(sys_clk),
        .rst_n(rst_n_i),
        .tif(tif)
    );

    assign tif.start = (state == RSS_HOLD) & ~any_src;
    assign tif.long_sel = long_sel;

    always_comb begin
        next_state = state;
        unique case (state)
            RSS_RUN: begin
                if (any_src) begin
                    next_state = RSS_HOLD;
                end
            end
            RSS_HOLD: begin
                if (!any_src) begin
                    next_state = RSS_DELAY;
                end
            end
            RSS_DELAY: begin
                if (any_src) begin
                    next_state = RSS_HOLD;
                end else if (!tif.busy) begin
                    next_state = RSS_RUN;
                end
            end
            default: begin
                next_state = RSS_HOLD;
            end
        endcase
    end

    assign next_long = (state == RSS_RUN) ? lvr_req : (long_sel | lvr_req);
    assign next_warm = (state == RSS_RUN) ? (wdt_run & ~(src_pin | lvr_req | wdt_ctl_fault))
                     : (warm & ~(src_pin | lvr_req | wdt_ctl_fault));

    always_ff @(posedge sys_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= RSS_HOLD;
            long_sel <= 1'b1;
            warm <= 1'b0;
            pc_sp_clear <= 1'b0;
        end else begin
            state <= next_state;
            long_sel <= next_long;
            warm <= next_warm;
            pc_sp_clear <= wdt_halt & (state == RSS_RUN);
        end
    end

    assign core_reset = (state != RSS_RUN);
    assign port_preset = core_reset;

    // ==========================================
    // Pin select and mode register
    logic full_rst;

    // Restore at release, so a held pin stays a reset source
    assign full_rst = tif.start & ~warm;

    always_ff @(posedge sys_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pinsel <= `RSS_PINSEL_POR;
            keep <= 1'b0;
            spare <= 1'b0;
        end else if (full_rst) begin
            pinsel <= `RSS_PINSEL_POR;
            keep <= 1'b0;
            spare <= 1'b0;
        end else begin
            if (wr_pinsel) begin
                pinsel <= (avs_writedata[7:0] & `RSS_PINSEL_WMASK) | (pinsel & ~`RSS_PINSEL_WMASK);
            end
            if (wr_mode1) begin
                keep <= avs_writedata[`RSS_M1_KEEP];
                spare <= avs_writedata[`RSS_M1_SPARE];
            end
        end
    end

    assign idle_clock_keep = keep;

    // ==========================================
    // Reset flags, set wins over clear
    logic clr_low_supply_flag, clr_wrf;

    assign clr_low_supply_flag = wr_mode1 & ~avs_writedata[`RSS_M1_LOW_SUPPLY_FLAG];
    assign clr_wrf = wr_mode1 & ~avs_writedata[`RSS_M1_WRF];

    always_ff @(posedge sys_clk or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_supply_flag <= 1'b0;
            watchdog_ctl_fault_flag <= 1'b0;
            to_flag <= 1'b0;
            powerdown_flag <= 1'b0;
        end else begin
            low_supply_flag <= lvr_req | (low_supply_flag & ~clr_low_supply_flag);
            watchdog_ctl_fault_flag <= wdt_ctl_fault | (watchdog_ctl_fault_flag & ~clr_wrf);
            to_flag <= wdt_timeout | (to_flag & ~(clr_wdt_exec | halt_exec));
            powerdown_flag <= halt_exec | (powerdown_flag & ~clr_wdt_exec);
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n_i);

    property p_pin_reset;
        !pin_s2 && pin_is_reset_fn |=> core_reset;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin low did not reset");

    property p_pin_release;
        state == RSS_HOLD && $rose(pin_s2) && !lvr_req && !src_evt |-> tif.start ##1 state == RSS_DELAY;
    endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin release did not start delay");

    property p_sel_code;
        wr_pinsel && avs_writedata[7:0] == `RSS_PINSEL_RESET && !full_rst |=> pin_is_reset_fn;
    endproperty
    a_sel_code: assert property (p_sel_code) else $error("reset code did not select reset pin");

    property p_warm_keep;
        state == RSS_HOLD && warm |=> $stable(pinsel);
    endproperty
    a_warm_keep: assert property (p_warm_keep) else $error("warm reset changed pin select");

    property p_full_restore;
        full_rst |=> pinsel == `RSS_PINSEL_POR && !keep;
    endproperty
    a_full_restore: assert property (p_full_restore) else $error("pin select not restored");

    property p_lvr_flag;
        lvr_req |=> low_supply_flag && core_reset && long_sel;
    endproperty
    a_lvr_flag: assert property (p_lvr_flag) else $error("low supply reset or flag missing");

    property p_low_supply_flag_noset;
        wr_mode1 && avs_writedata[`RSS_M1_LOW_SUPPLY_FLAG] && !low_supply_flag && !lvr_req |=> !low_supply_flag;
    endproperty
    a_low_supply_flag_noset: assert property (p_low_supply_flag_noset) else $error("software set low supply flag");

    property p_rsvd_zero;
        req && !ack && hit_mode1 |=> avs_readdata[6:4] == 3'h0 && avs_readdata[1] == 1'b0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("unimplemented bits not zero");

    property p_wdt_run;
        wdt_run |=> to_flag && core_reset;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog time-out not handled");

    property p_wrf_set;
        wdt_ctl_fault |=> watchdog_ctl_fault_flag && core_reset;
    endproperty
    a_wrf_set: assert property (p_wrf_set) else $error("control fault flag not set");

    property p_halt_wdt;
        wdt_halt && state == RSS_RUN && !src_pin && !lvr_req && !wdt_ctl_fault |=>
            pc_sp_clear && to_flag && !core_reset;
    endproperty
    a_halt_wdt: assert property (p_halt_wdt) else $error("halted time-out mishandled");

    property p_any_src;
        any_src |=> core_reset [*2];
    endproperty
    a_any_src: assert property (p_any_src) else $error("reset released with active source");

    property p_delay_hold;
        state == RSS_DELAY && tif.busy |=> core_reset;
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("reset released during delay");

    c_por_done: cover property ($fell(core_reset) && long_sel);
    c_pin_reset: cover property (src_pin ##[1:300] state == RSS_DELAY);
    c_lvr_reset: cover property ($rose(lvr_req));
    c_halt_wdt: cover property (pc_sp_clear);
endmodule // rss_reset_seq

/* hdl/rss_defines.svh */
// Offsets, field positions, reset values and timing counts of the reset sequencer.
// Assumes a 25 MHz system clock and byte addresses on the register bus.
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// ==========================================
// Clock
`define RSS_CLK_MHZ 25

// ==========================================
// Register byte offsets
`define RSS_OFS_PINSEL 4'h0
`define RSS_OFS_MODE1 4'h4
`define RSS_OFS_STAT 4'h8

// ==========================================
// Pin function codes and reset values
`define RSS_PINSEL_GPIO 8'h55
`define RSS_PINSEL_RESET 8'hAA
`define RSS_PINSEL_POR `RSS_PINSEL_GPIO
`define RSS_PINSEL_WMASK 8'hF3

// ==========================================
// Field positions
`define RSS_M1_KEEP 7
`define RSS_M1_SPARE 3
`define RSS_M1_LOW_SUPPLY_FLAG 2
`define RSS_M1_WRF 0
`define RSS_ST_TO 0
`define RSS_ST_PDF 1

// ==========================================
// Timing
`define RSS_T_LONG_US 50000
`define RSS_T_SHORT_US 16700
`define RSS_T_QUAL_US 100
`define RSS_LONG_CYC (`RSS_T_LONG_US * `RSS_CLK_MHZ)
`define RSS_SHORT_CYC (`RSS_T_SHORT_US * `RSS_CLK_MHZ)
`define RSS_QUAL_CYC (`RSS_T_QUAL_US * `RSS_CLK_MHZ)
`define RSS_LVR_OSC_EDGES 3
`define RSS_TMR_W 21

`endif

/* hdl/rss_pkg.sv */
// Types shared by the reset sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package rss_pkg;

    // ==========================================
    // Sequencer states
    typedef enum logic [2:0] {
        RSS_RUN = 3'b001,
        RSS_HOLD = 3'b010,
        RSS_DELAY = 3'b100
    } rss_state_t;

endpackage

/* hdl/rss_tmr_if.sv */
// Start and status wires between the sequencer and its start-up timer.
// Assumes both ends run on sys_clk.
interface rss_tmr_if;
    logic start;
    logic long_sel;
    logic busy;

    modport ctrl (output start, output long_sel, input busy);
    modport tmr (input start, input long_sel, output busy);
endinterface

/* hdl/rss_start_timer.sv */
// Start-up timer: counts the long or short start delay after a start pulse.
// Assumes a synchronous start pulse and a synchronised reset.
`include "rss_defines.svh"
module rss_start_timer
    import rss_pkg::*;
#(
    parameter int unsigned LONG_CYC = `RSS_LONG_CYC,
    parameter int unsigned SHORT_CYC = `RSS_SHORT_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    rss_tmr_if.tmr tif
);
    localparam logic [`RSS_TMR_W-1:0] LOAD_LONG = `RSS_TMR_W'(LONG_CYC - 1);
    localparam logic [`RSS_TMR_W-1:0] LOAD_SHORT = `RSS_TMR_W'(SHORT_CYC - 1);

    logic [`RSS_TMR_W-1:0] cnt;
    logic [`RSS_TMR_W-1:0] next_cnt;

    assign next_cnt = tif.start ? (tif.long_sel ? LOAD_LONG : LOAD_SHORT)
                    : (cnt != '0) ? cnt - 1'b1 : cnt;
    assign tif.busy = (cnt != '0);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // ==========================================
    // Checks
    property p_tmr_long;
        @(posedge sys_clk) disable iff (!rst_n)
        tif.start && tif.long_sel |=> cnt == LOAD_LONG;
    endproperty
    a_tmr_long: assert property (p_tmr_long) else $error("long delay load wrong");

    property p_tmr_short;
        @(posedge sys_clk) disable iff (!rst_n)
        tif.start && !tif.long_sel |=> cnt == LOAD_SHORT;
    endproperty
    a_tmr_short: assert property (p_tmr_short) else $error("short delay load wrong");

    property p_tmr_down;
        @(posedge sys_clk) disable iff (!rst_n)
        !tif.start && cnt > 1 |=> tif.busy && cnt == $past(cnt) - 1'b1;
    endproperty
    a_tmr_down: assert property (p_tmr_down) else $error("timer not counting down");
endmodule // rss_start_timer

/* hdl/rss_lvr_qual.sv */
// Low-supply qualifier: persistence filter, then reset after the third rising slow oscillator edge.
// Assumes low_supply_det and slow_internal_osc are asynchronous pins.
`include "rss_defines.svh"
module rss_lvr_qual
    import rss_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic low_supply_det,
    input wire logic slow_internal_osc,
    input wire logic monitor_on,
    output logic lvr_req
);
    localparam logic [11:0] QUAL = 12'(`RSS_QUAL_CYC);
    localparam logic [1:0] EDGES = 2'(`RSS_LVR_OSC_EDGES);

    logic sup_s1, sup_s2, osc_s1, osc_s2, osc_d;
    logic [11:0] qcnt;
    logic [1:0] ecnt;
    logic qual_done, osc_rise, active;

    assign qual_done = (qcnt == QUAL);
    assign osc_rise = osc_s2 & ~osc_d;
    assign active = monitor_on & sup_s2;
    assign lvr_req = (ecnt == EDGES);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {sup_s1, sup_s2, osc_s1, osc_s2, osc_d} <= 5'h00;
        end else begin
            {sup_s2, sup_s1} <= {sup_s1, low_supply_det};
            {osc_d, osc_s2, osc_s1} <= {osc_s2, osc_s1, slow_internal_osc};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            qcnt <= 12'h000;
            ecnt <= 2'h0;
        end else if (!active) begin
            qcnt <= 12'h000;
            ecnt <= 2'h0;
        end else if (!qual_done) begin
            qcnt <= qcnt + 12'h001;
        end else if (osc_rise && !lvr_req) begin
            ecnt <= ecnt + 2'h1;
        end
    end

    // ==========================================
    // Checks
    property p_lvr_qual;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(lvr_req) |-> qual_done && $past(qual_done) && sup_s2;
    endproperty
    a_lvr_qual: assert property (p_lvr_qual) else $error("low supply reset before qualification");

    property p_lvr_off;
        @(posedge sys_clk) disable iff (!rst_n)
        !monitor_on |=> !lvr_req && qcnt == 12'h000;
    endproperty
    a_lvr_off: assert property (p_lvr_off) else $error("monitor active in sleep or idle");

    property p_lvr_edge;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(lvr_req) |-> $past(osc_rise);
    endproperty
    a_lvr_edge: assert property (p_lvr_edge) else $error("reset not on oscillator edge");
endmodule // rss_lvr_qual

/* tb/rss_ext_reset_circuit.sv */
// Model of the external reset circuit that drives the reset pin.
// Assumes the bench asks for a press and gives the RC hold time in sys_clk cycles.
module rss_ext_reset_circuit (
    input wire logic sys_clk,
    input wire logic press,
    input wire logic [7:0] rc_len,
    output logic pin_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] hold_cnt;
    initial begin
        pin_n = 1'b1;
        hold_cnt = 8'h00;
    end
    // ==========================================
    // Pull low while pressed, then RC hold, then pull-up
    always @(posedge sys_clk) begin
        if (press) begin
            pin_n <= 1'b0;
            hold_cnt <= rc_len;
        end else if (hold_cnt != 8'h00) begin
            hold_cnt <= hold_cnt - 8'h01;
        end else begin
            pin_n <= 1'b1;
        end
    end
endmodule // rss_ext_reset_circuit

/* tb/rss_reset_seq_bench.sv */
// Self-checking bench of the reset source sequencer.
// Assumes shortened delays and the external reset circuit model on the pin.
`include "rss_defines.svh"
module rss_reset_seq_bench;
    import rss_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LONG_T = 200;
    localparam int SHORT_T = 80;
    logic sys_clk, reset_n, avs_read, avs_write, avs_waitrequest, pin_n, press, low_supply_det, osc, cpu_halted;
    logic [3:0] avs_address, ev;
    logic [31:0] avs_writedata, avs_readdata, rng;
    logic [7:0] rc_len, v;
    logic [1:0] osc_cnt;
    logic core_reset, port_preset, pc_sp_clear, pin_is_reset_fn, idle_clock_keep;
    int n_mismatch, check_count, cyc, n;
    // ==========================================
    // Design, partner and clocks
    rss_reset_seq #(.LONG_CYC(LONG_T), .SHORT_CYC(SHORT_T)) rss_reset_seq_i (.sys_clk(sys_clk), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_init_pin_n(pin_n),
        .low_supply_det(low_supply_det), .slow_internal_osc(osc), .cpu_halted(cpu_halted),
        .wdt_timeout(ev[0]), .wdt_ctl_fault(ev[1]), .halt_exec(ev[2]), .clr_wdt_exec(ev[3]),
        .core_reset(core_reset), .port_preset(port_preset), .pc_sp_clear(pc_sp_clear),
        .pin_is_reset_fn(pin_is_reset_fn), .idle_clock_keep(idle_clock_keep));
    rss_ext_reset_circuit rss_ext_reset_circuit_i (.sys_clk(sys_clk), .press(press), .rc_len(rc_len), .pin_n(pin_n));
    initial sys_clk = 1'b0;
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        osc_cnt <= osc_cnt + 2'h1;
        if (osc_cnt == 2'h3) osc <= ~osc;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            $display("BAD run length expected below 20000 seen 20000");
            complete_run();
        end
    end
    // ==========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [7:0] pinsel_rd(input logic [7:0] w);
        return (w & `RSS_PINSEL_WMASK) | 8'h04;
    endfunction
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic chk1(input string what, input logic e, input logic g);
        chk8(what, {7'h0, e}, {7'h0, g});
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int g);
        check_count++;
        if (g < lo || g > hi) begin
            n_mismatch++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, g);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        int k = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk_rng("bus wait cycles", 2, 2, k);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string what);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        chk8(what, e, r);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic wait_core(input logic val, input int lim, output int k);
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (core_reset !== val && k < lim);
    endtask
    task automatic watch(input int lim, output int hi);
        hi = 0;
        repeat (lim) begin
            @(negedge sys_clk);
            if (core_reset !== 1'b0) hi++;
        end
    endtask
    task automatic pulse(input int idx);
        @(posedge sys_clk);
        ev[idx] <= 1'b1;
        @(posedge sys_clk);
        ev[idx] <= 1'b0;
    endtask
    task automatic press_pin(input int len, input logic fire_wdt);
        @(posedge sys_clk);
        press <= 1'b1;
        repeat (len) @(posedge sys_clk);
        if (fire_wdt) pulse(0);
        press <= 1'b0;
        n = 0;
        while (pin_n !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task automatic endt(input string what);
        $display("test %s finished", what);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        {reset_n, avs_read, avs_write, press, low_supply_det, osc, cpu_halted} = 7'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        ev = 4'h0;
        osc_cnt = 2'h0;
        rc_len = 8'h04;
        rng = 32'h0000E38F;
        n_mismatch = 0;
        check_count = 0;
        cyc = 0;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        chk1("core_reset in reset", 1'b1, core_reset);
        chk1("port_preset in reset", 1'b1, port_preset);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        wait_core(1'b0, 1000, n);
        chk_rng("power-on delay", LONG_T, LONG_T + 8, n);
        rd_chk(`RSS_OFS_PINSEL, `RSS_PINSEL_POR, "pin select");
        rd_chk(`RSS_OFS_MODE1, 8'h00, "mode1");
        rd_chk(`RSS_OFS_STAT, 8'h00, "status");
        endt("power-on");
        for (int i = 0; i < 6; i++) begin
            rng = xs(rng);
            v = rng[7:0];
            wr(`RSS_OFS_MODE1, v);
            rd_chk(`RSS_OFS_MODE1, v & 8'h88, "mode1 random");
            chk1("idle_clock_keep", v[7], idle_clock_keep);
            wr(4'hC, rng[15:8]);
            rd_chk(4'hC, 8'h00, "unmapped");
        end
        endt("registers");
        press_pin(10, 1'b0);
        watch(60, n);
        chk_rng("pin ignored in general use", 0, 0, n);
        wr(`RSS_OFS_PINSEL, `RSS_PINSEL_RESET);
        rd_chk(`RSS_OFS_PINSEL, pinsel_rd(`RSS_PINSEL_RESET), "pin select reset code");
        chk1("pin_is_reset_fn", 1'b1, pin_is_reset_fn);
        rng = xs(rng);
        rc_len = {4'h0, rng[3:0]};
        press_pin(30, 1'b1);
        chk1("core_reset while pin low", 1'b1, core_reset);
        wait_core(1'b0, 400, n);
        chk_rng("pin delay", SHORT_T, SHORT_T + 8, n);
        rd_chk(`RSS_OFS_PINSEL, `RSS_PINSEL_POR, "pin select after pin reset");
        endt("pin reset");
        wr(`RSS_OFS_PINSEL, `RSS_PINSEL_RESET);
        pulse(3);
        rd_chk(`RSS_OFS_STAT, 8'h00, "status before watchdog");
        pulse(0);
        wait_core(1'b1, 10, n);
        chk1("core_reset on watchdog", 1'b1, core_reset);
        wait_core(1'b0, 400, n);
        chk_rng("watchdog delay", SHORT_T, SHORT_T + 8, n);
        rd_chk(`RSS_OFS_STAT, 8'h01, "status after watchdog");
        rd_chk(`RSS_OFS_PINSEL, pinsel_rd(`RSS_PINSEL_RESET), "pin select kept");
        endt("watchdog running");
        pulse(1);
        wait_core(1'b1, 10, n);
        wait_core(1'b0, 400, n);
        chk_rng("fault delay", SHORT_T, SHORT_T + 8, n);
        rd_chk(`RSS_OFS_MODE1, 8'h01, "fault flag");
        rd_chk(`RSS_OFS_PINSEL, `RSS_PINSEL_POR, "pin select after fault");
        wr(`RSS_OFS_MODE1, 8'hFF);
        rd_chk(`RSS_OFS_MODE1, 8'h89, "fault flag write one");
        wr(`RSS_OFS_MODE1, 8'h00);
        rd_chk(`RSS_OFS_MODE1, 8'h00, "fault flag cleared");
        endt("control fault");
        pulse(2);
        rd_chk(`RSS_OFS_STAT, 8'h02, "status after halt");
        cpu_halted <= 1'b1;
        pulse(0);
        @(negedge sys_clk);
        chk1("pc_sp_clear", 1'b1, pc_sp_clear);
        @(negedge sys_clk);
        chk1("pc_sp_clear width", 1'b0, pc_sp_clear);
        watch(20, n);
        chk_rng("no core reset when halted", 0, 0, n);
        rd_chk(`RSS_OFS_STAT, 8'h03, "status halted watchdog");
        endt("watchdog halted");
        cpu_halted <= 1'b0;
        low_supply_det <= 1'b1;
        repeat (1000) @(posedge sys_clk);
        low_supply_det <= 1'b0;
        watch(2700, n);
        chk_rng("short low supply", 0, 0, n);
        cpu_halted <= 1'b1;
        low_supply_det <= 1'b1;
        watch(3000, n);
        chk_rng("low supply while halted", 0, 0, n);
        cpu_halted <= 1'b0;
        wait_core(1'b1, 3000, n);
        chk_rng("low supply reaction", 2500, 2560, n);
        low_supply_det <= 1'b0;
        wait_core(1'b0, 1000, n);
        chk_rng("low supply delay", LONG_T, LONG_T + 10, n);
        rd_chk(`RSS_OFS_MODE1, 8'h04, "low supply flag");
        rd_chk(`RSS_OFS_STAT, 8'h03, "status after low supply");
        wr(`RSS_OFS_MODE1, 8'hFF);
        rd_chk(`RSS_OFS_MODE1, 8'h8C, "low supply flag write one");
        wr(`RSS_OFS_MODE1, 8'h00);
        rd_chk(`RSS_OFS_MODE1, 8'h00, "low supply flag cleared");
        pulse(3);
        rd_chk(`RSS_OFS_STAT, 8'h00, "status after clear");
        endt("low supply");
        complete_run();
    end
endmodule // rss_reset_seq_bench
